// file: tvsc_pkg.sv
// tvsc_pkg: constants and carrier types for the tuning voltage store control
// assumes a 100 MHz system clock and a separate resonator clock for the pulse
package tvsc_pkg;
  // word and preset sizes
  localparam int unsigned WORD_W = 10;
  localparam int unsigned KEY_N = 8;
  localparam int unsigned ADDR_W = 3;
  localparam int unsigned SUB_W = 3;
  // system clock rate
  localparam int unsigned CLK_HZ = 100_000_000;
  // scale mode counting rate, in Hz
  localparam int unsigned TRACK_HZ = 250;
  localparam int unsigned TRACK_CYC = CLK_HZ / TRACK_HZ;
  // retune span, in ms
  localparam int unsigned RETUNE_MS = 1000;
  localparam int unsigned RETUNE_CYC = (CLK_HZ / 1000) * RETUNE_MS;
  // growth of the step period per retune step, as a divisor of TRACK_CYC
  localparam int unsigned SLOW_DIV = 16;
  localparam int unsigned SLOW_INC = TRACK_CYC / SLOW_DIV;
  // half period of the memory shift clock, in us
  localparam int unsigned HALF_US = 50;
  localparam int unsigned HALF_CYC = (CLK_HZ / 1_000_000) * HALF_US;
  // command set-up time before the first shift clock, in us
  localparam int unsigned SETUP_US = 100;
  localparam int unsigned SETUP_CYC = (CLK_HZ / 1_000_000) * SETUP_US;
  // wait for the memory to erase and write, in ms
  localparam int unsigned PROG_MS = 1000;
  localparam int unsigned PROG_CYC = (CLK_HZ / 1000) * PROG_MS;
  // reset value of the tuning word
  localparam logic [9:0] WORD_RST = 10'h000;
  localparam logic [9:0] WORD_MAX = 10'h3FF;
  localparam logic [3:0] LAST_BIT = 4'h9;

  // sequencer states
  typedef enum logic [2:0] {
    ST_IDLE = 3'b000,
    ST_RETUNE = 3'b001,
    ST_SETUP = 3'b010,
    ST_SHI = 3'b011,
    ST_SLO = 3'b100,
    ST_PROG = 3'b101
  } tvsc_state_t;

  // lines towards the serial memory
  typedef struct packed {
    logic [2:0] addr;
    logic shift_clk;
    logic recall_strobe_n;
    logic write_command_out_n;
    logic memory_timing_aux;
    logic memory_clear_out;
  } tvsc_mem_t;
endpackage : tvsc_pkg

// file: tvsc_ctrl.sv
// tvsc_ctrl: tuning word store, pulse width output, key logic, memory link
// assumes synchronous logic on clock; osc_clk is the resonator clock and
// runs free; all pins but ce are asynchronous and are synchronised here
`timescale 1ns/1ps
module tvsc_ctrl
  import tvsc_pkg::*;
#(
  parameter int unsigned TRACK_CYCLES = TRACK_CYC,
  parameter int unsigned RETUNE_CYCLES = RETUNE_CYC,
  parameter int unsigned SLOW_STEP = SLOW_INC,
  parameter int unsigned HALF_CYCLES = HALF_CYC,
  parameter int unsigned SETUP_CYCLES = SETUP_CYC,
  parameter int unsigned PROG_CYCLES = PROG_CYC
)
(
  // system clock, reset, enable
  input wire logic clock,
  input wire logic nrst,
  input wire logic ce,
  // resonator clock for the pulse width output
  input wire logic osc_clk,
  // user keys, active high
  input wire logic [KEY_N-1:0] preset_key,
  input wire logic store_key,
  input wire logic scale_key,
  // comparator direction, high when the word must rise
  input wire logic comp_up,
  // power-up level from the memory
  input wire logic power_up,
  // shared serial data pin
  input wire logic serial_word_i,
  output logic serial_word_o,
  output logic serial_word_oe,
  // memory control lines
  output tvsc_mem_t mem_ctl,
  // pulse width output and mute
  output logic pulse_out,
  output logic mute
);

  // reset release and synchronisers
  logic [1:0] rst_sync_q; // reset release chain
  logic rst_n; // released reset
  logic [KEY_N+4:0] in_s1_q; // first stage, read only by stage two
  logic [KEY_N+4:0] in_s2_q; // synchronised pins
  logic [KEY_N-1:0] keys_s;
  logic store_s, scale_s, comp_s, pwr_s, ser_s;

  // key logic
  logic [KEY_N-1:0] keys_prev_q; // keys one cycle ago
  logic [KEY_N-1:0] key_rise; // newly pressed keys
  logic key_evt; // one clean new press
  logic [ADDR_W-1:0] sel_q; // active preset
  logic [ADDR_W-1:0] sel_d; // active preset after this cycle's keys
  logic store_prev_q, store_armed_q, pwr_prev_q;
  logic pwr_evt; // power-up rise with one key held

  // sequencer
  tvsc_state_t state_q;
  logic is_write_q; // current transfer is a write
  logic [31:0] tmr_q; // state timer
  logic [3:0] bit_q; // bit index within the word
  logic shift_in; // sample one recalled bit

  // counting
  logic [31:0] step_cnt_q; // counting clock divider
  logic [31:0] period_q; // counting clock period
  logic step_en; // counting is active
  logic step_tick; // one counting clock
  logic [WORD_W-1:0] word_q; // tuning word
  logic [31:0] match_q; // time since the comparator turned
  logic comp_prev_q;

  // crossing into the resonator domain
  logic xreq_q; // request toggle, system side
  logic [WORD_W-1:0] xword_q; // word held for the crossing
  logic [1:0] ack_sync_q; // ack toggle synchroniser
  logic [1:0] orst_q; // reset release, resonator side
  logic [1:0] req_sync_q; // req toggle synchroniser
  logic req_seen_q; // last req taken, drives ack
  logic [WORD_W-1:0] oword_q; // word used by the pulse logic
  logic [WORD_W-1:0] cyc_q; // cycle counter
  logic pulse_q;

  // decoding used by the key logic and power-up check
  function automatic logic one_hot(input logic [KEY_N-1:0] v);
    logic r;
    r = (v != '0) && ((v & (v - 1'b1)) == '0);
    return r;
  endfunction : one_hot

  function automatic logic [ADDR_W-1:0] encode(input logic [KEY_N-1:0] v);
    logic [ADDR_W-1:0] r;
    r = '0;
    for (int i = 0; i < KEY_N; i++)
    begin
      if (v[i])
      begin
        r = ADDR_W'(i);
      end
    end
    return r;
  endfunction : encode

  // reset release through two flops
  always_ff @(posedge clock or negedge nrst)
  begin
    if (!nrst)
      rst_sync_q <= 2'h0;
    else
      rst_sync_q <= {rst_sync_q[0], 1'b1};
  end
  assign rst_n = rst_sync_q[1];

  // two flops on every pin input but ce
  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
    begin
      in_s1_q <= '0;
      in_s2_q <= '0;
    end
    else if (ce)
    begin
      in_s1_q <= {preset_key, store_key, scale_key, comp_up, power_up,
                  serial_word_i};
      in_s2_q <= in_s1_q;
    end
  end
  assign {keys_s, store_s, scale_s, comp_s, pwr_s, ser_s} = in_s2_q;

  // key press detection
  assign key_rise = keys_s & ~keys_prev_q;
  assign key_evt = one_hot(key_rise);
  assign pwr_evt = pwr_s && !pwr_prev_q && one_hot(keys_s);
  // latest clean press wins; power-up takes the one key held
  assign sel_d = key_evt ? encode(key_rise) :
                 pwr_evt ? encode(keys_s) : sel_q;

  // preset selection and store arming
  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
    begin
      keys_prev_q <= '0;
      sel_q <= '0;
      store_prev_q <= 1'b0;
      store_armed_q <= 1'b0;
      pwr_prev_q <= 1'b0;
    end
    else if (ce)
    begin
      keys_prev_q <= keys_s;
      store_prev_q <= store_s;
      pwr_prev_q <= pwr_s;
      // selection follows every clean press, busy or not
      sel_q <= sel_d;
      // store press arms; arming wins over consumption
      if (store_s && !store_prev_q)
        store_armed_q <= 1'b1;
      else if (key_evt && state_q == ST_IDLE)
        store_armed_q <= 1'b0;
    end
  end

  // sequencer for retune, recall and write
  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
    begin
      state_q <= ST_IDLE;
      is_write_q <= 1'b0;
      tmr_q <= '0;
      bit_q <= '0;
      mem_ctl <= '{addr: 3'h0, shift_clk: 1'b0, recall_strobe_n: 1'b1,
                   write_command_out_n: 1'b1, memory_timing_aux: 1'b0,
                   memory_clear_out: 1'b0};
      serial_word_o <= 1'b0;
      serial_word_oe <= 1'b0;
    end
    else if (ce)
    begin
      mem_ctl.memory_clear_out <= 1'b1;
      tmr_q <= tmr_q + 32'h1;
      unique case (state_q)
        ST_IDLE:
        begin
          tmr_q <= '0;
          // store needs the arm, a recall needs only the key
          if (key_evt && store_armed_q)
          begin
            is_write_q <= 1'b1;
            mem_ctl.addr <= sel_d;
            state_q <= ST_RETUNE;
          end
          else if (key_evt || pwr_evt)
          begin
            is_write_q <= 1'b0;
            mem_ctl.addr <= sel_d;
            state_q <= ST_SETUP;
          end
        end
        ST_RETUNE:
        begin
          // slowing count runs for the whole span
          if (tmr_q >= 32'(RETUNE_CYCLES) - 32'h1)
          begin
            tmr_q <= '0;
            state_q <= ST_SETUP;
          end
        end
        ST_SETUP:
        begin
          // command and aux before the first clock
          mem_ctl.memory_timing_aux <= 1'b1;
          mem_ctl.recall_strobe_n <= is_write_q;
          mem_ctl.write_command_out_n <= !is_write_q;
          serial_word_oe <= is_write_q;
          serial_word_o <= is_write_q & word_q[WORD_W-1];
          bit_q <= '0;
          if (tmr_q >= 32'(SETUP_CYCLES) - 32'h1)
          begin
            tmr_q <= '0;
            mem_ctl.shift_clk <= 1'b1;
            state_q <= ST_SHI;
          end
        end
        ST_SHI:
        begin
          // clock high; memory moves on the falling edge
          if (tmr_q >= 32'(HALF_CYCLES) - 32'h1)
          begin
            tmr_q <= '0;
            mem_ctl.shift_clk <= 1'b0;
            state_q <= ST_SLO;
          end
        end
        ST_SLO:
        begin
          if (tmr_q >= 32'(HALF_CYCLES) - 32'h1)
          begin
            tmr_q <= '0;
            if (bit_q == LAST_BIT)
            begin
              mem_ctl.recall_strobe_n <= 1'b1;
              mem_ctl.write_command_out_n <= 1'b1;
              mem_ctl.memory_timing_aux <= 1'b0;
              serial_word_oe <= 1'b0;
              serial_word_o <= 1'b0;
              state_q <= is_write_q ? ST_PROG : ST_IDLE;
            end
            else
            begin
              // next bit, most significant first
              bit_q <= bit_q + 4'h1;
              serial_word_o <= is_write_q &
                word_q[LAST_BIT - (bit_q + 4'h1)];
              mem_ctl.shift_clk <= 1'b1;
              state_q <= ST_SHI;
            end
          end
        end
        ST_PROG:
        begin
          // memory erases and writes, then read back
          if (tmr_q >= 32'(PROG_CYCLES) - 32'h1)
          begin
            tmr_q <= '0;
            is_write_q <= 1'b0;
            state_q <= ST_SETUP;
          end
        end
        default:
        begin
          state_q <= ST_IDLE;
        end
      endcase
    end
  end

  // recall samples just before the falling edge
  assign shift_in = (state_q == ST_SHI) && !is_write_q &&
                    (tmr_q >= 32'(HALF_CYCLES) - 32'h1);

  // counting clock: fixed in scale mode, slowing in retune
  assign step_en = (state_q == ST_RETUNE) ||
                   (state_q == ST_IDLE && scale_s && !store_s);
  assign step_tick = step_en && (step_cnt_q >= period_q - 32'h1);

  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
    begin
      step_cnt_q <= '0;
      period_q <= 32'(TRACK_CYCLES);
    end
    else if (ce)
    begin
      if (!step_en)
      begin
        step_cnt_q <= '0;
        period_q <= 32'(TRACK_CYCLES);
      end
      else if (step_tick)
      begin
        step_cnt_q <= '0;
        if (state_q == ST_RETUNE)
          period_q <= period_q + 32'(SLOW_STEP);
      end
      else
        step_cnt_q <= step_cnt_q + 32'h1;
    end
  end

  // tuning word: counter or shift register
  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
      word_q <= WORD_RST;
    else if (ce)
    begin
      if (shift_in)
        word_q <= {word_q[WORD_W-2:0], ser_s};
      else if (step_tick)
      begin
        // direction only, saturating at both ends
        if (comp_s && word_q != WORD_MAX)
          word_q <= word_q + 10'h001;
        else if (!comp_s && word_q != WORD_RST)
          word_q <= word_q - 10'h001;
      end
    end
  end

  // mute: whole sequence, or store held away from equality
  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
    begin
      comp_prev_q <= 1'b0;
      match_q <= 32'(TRACK_CYCLES);
      mute <= 1'b1;
    end
    else if (ce)
    begin
      comp_prev_q <= comp_s;
      // a turn of the comparator marks equality for a while
      if (comp_s != comp_prev_q)
        match_q <= '0;
      else if (match_q < 32'(TRACK_CYCLES))
        match_q <= match_q + 32'h1;
      mute <= (state_q != ST_IDLE) ||
              (store_s && match_q >= 32'(TRACK_CYCLES));
    end
  end

  // hand the word to the resonator side when it is free
  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
    begin
      xreq_q <= 1'b0;
      xword_q <= WORD_RST;
      ack_sync_q <= 2'h0;
    end
    else if (ce)
    begin
      ack_sync_q <= {ack_sync_q[0], req_seen_q};
      if (ack_sync_q[1] == xreq_q && xword_q != word_q)
      begin
        xword_q <= word_q;
        xreq_q <= !xreq_q;
      end
    end
  end

  // resonator side reset release
  always_ff @(posedge osc_clk or negedge nrst)
  begin
    if (!nrst)
      orst_q <= 2'h0;
    else
      orst_q <= {orst_q[0], 1'b1};
  end

  // take a new word when the request toggle arrives
  always_ff @(posedge osc_clk or negedge orst_q[1])
  begin
    if (!orst_q[1])
    begin
      req_sync_q <= 2'h0;
      req_seen_q <= 1'b0;
      oword_q <= WORD_RST;
    end
    else
    begin
      req_sync_q <= {req_sync_q[0], xreq_q};
      if (req_sync_q[1] != req_seen_q)
      begin
        req_seen_q <= req_sync_q[1];
        oword_q <= xword_q; // held stable until ack
      end
    end
  end

  // cycle counter and pulse flip-flop
  always_ff @(posedge osc_clk or negedge orst_q[1])
  begin
    if (!orst_q[1])
    begin
      cyc_q <= '0;
      pulse_q <= 1'b0;
    end
    else
    begin
      cyc_q <= cyc_q + 10'h001;
      // eight sub-pulses; low bits spread one extra count each
      if (cyc_q[WORD_W-SUB_W-1:0] == '0)
        pulse_q <= (oword_q[WORD_W-1:SUB_W] != '0) ||
                   (cyc_q[WORD_W-1:WORD_W-SUB_W] < oword_q[SUB_W-1:0]);
      else if (cyc_q[WORD_W-SUB_W-1:0] == {1'b0, oword_q[WORD_W-1:SUB_W]} +
               7'((cyc_q[WORD_W-1:WORD_W-SUB_W] < oword_q[SUB_W-1:0])))
        pulse_q <= 1'b0;
    end
  end
  assign pulse_out = pulse_q;

endmodule : tvsc_ctrl

// file: tvsc_ctrl_monitor.sv
// tvsc_ctrl_monitor: port checks on the memory link and the mute line
// assumes it is bound into tvsc_ctrl and sees only the top ports
`timescale 1ns/1ps
module tvsc_ctrl_monitor
  import tvsc_pkg::*;
#(
  parameter int unsigned HALF_CYCLES = HALF_CYC
)
(
  // clock and reset
  input wire logic clock,
  input wire logic nrst,
  // watched outputs
  input wire tvsc_mem_t mem_ctl,
  input wire logic serial_word_oe,
  input wire logic mute
);
  logic cmd; // either memory command active
  logic [7:0] hi_q; // cycles of the current shift clock high
  logic [4:0] np_q; // shift clock pulses within one command
  assign cmd = !mem_ctl.recall_strobe_n || !mem_ctl.write_command_out_n;
  // length of the shift clock high phase
  always_ff @(posedge clock or negedge nrst)
  begin
    if (!nrst) hi_q <= 8'h00;
    else if (mem_ctl.shift_clk) hi_q <= hi_q + 8'h01;
    else hi_q <= 8'h00;
  end
  // pulses counted while a command stands
  always_ff @(posedge clock or negedge nrst)
  begin
    if (!nrst) np_q <= 5'h00;
    else if (!cmd) np_q <= 5'h00;
    else if ($rose(mem_ctl.shift_clk)) np_q <= np_q + 5'h01;
  end
  default clocking cb @(posedge clock); endclocking
  default disable iff (!nrst);
  chk_mute_cmd: assert property (cmd && $past(cmd) |-> mute)
    else $error("mute low during a memory command");
  chk_aux_cmd: assert property (mem_ctl.memory_timing_aux == cmd)
    else $error("aux line not paired with a command");
  chk_cmd_excl: assert property (!(!mem_ctl.recall_strobe_n &&
    !mem_ctl.write_command_out_n))
    else $error("recall and write asserted together");
  chk_oe_recall: assert property (!mem_ctl.recall_strobe_n |->
    !serial_word_oe)
    else $error("data pin driven during recall");
  chk_oe_write: assert property (serial_word_oe |->
    !mem_ctl.write_command_out_n)
    else $error("data pin driven outside a write");
  chk_addr_hold: assert property (cmd && $past(cmd) |->
    $stable(mem_ctl.addr))
    else $error("address moved during a command");
  chk_clk_in_cmd: assert property (mem_ctl.shift_clk |-> cmd)
    else $error("shift clock outside a command");
  chk_high_len: assert property ($fell(mem_ctl.shift_clk) |->
    hi_q == 8'(HALF_CYCLES))
    else $error("shift clock high phase of wrong length");
  chk_ten_recall: assert property ($rose(mem_ctl.recall_strobe_n) |->
    np_q == 5'h0A)
    else $error("recall without ten shift clocks");
  chk_ten_write: assert property ($rose(mem_ctl.write_command_out_n) |->
    np_q == 5'h0A)
    else $error("write without ten shift clocks");
endmodule : tvsc_ctrl_monitor

// file: tvsc_mem_model.sv
// tvsc_mem_model: behavioural serial tuning memory of eight words
// assumes the device's registered memory lines on the system clock
`timescale 1ns/1ps
module tvsc_mem_model
  import tvsc_pkg::*;
(
  // system clock
  input wire logic clock,
  // lines from the device
  input wire tvsc_mem_t mem_ctl,
  input wire logic serial_word_o,
  input wire logic serial_word_oe,
  // data towards the device
  output logic serial_word_i
);
  logic [9:0] mem [8]; // stored words
  logic [9:0] sh_q; // shift register
  logic [2:0] a_q; // address taken at command start
  logic sc_q, rd_q, wr_q, tog_q; // last clock, commands, idle pattern
  // preload with a known pattern
  initial
  begin
    for (int i = 0; i < 8; i++) mem[i] = 10'(i * 123 + 3);
    {sc_q, rd_q, wr_q, tog_q, sh_q, a_q} = '0;
  end
  // released line shows no stale bit
  assign serial_word_i = (rd_q && !mem_ctl.recall_strobe_n) ? sh_q[9] : tog_q;
  // read out on recall, take in on write
  always @(posedge clock)
  begin
    sc_q <= mem_ctl.shift_clk;
    rd_q <= !mem_ctl.recall_strobe_n;
    wr_q <= !mem_ctl.write_command_out_n;
    tog_q <= ~tog_q;
    if (!mem_ctl.recall_strobe_n && !rd_q)
    begin
      sh_q <= mem[mem_ctl.addr];
      a_q <= mem_ctl.addr;
    end
    else if (!mem_ctl.write_command_out_n && !wr_q) a_q <= mem_ctl.addr;
    else if (sc_q && !mem_ctl.shift_clk)
      sh_q <= {sh_q[8:0], serial_word_oe ? serial_word_o : tog_q};
    if (mem_ctl.write_command_out_n && wr_q) mem[a_q] <= sh_q;
  end
endmodule : tvsc_mem_model

// file: tb_tvsc_ctrl.sv
// tb_tvsc_ctrl: self-checking bench of the tuning word controller
// assumes the memory model and the monitor sit in the same folder
`timescale 1ns/1ps
module tb_tvsc_ctrl;
  import tvsc_pkg::*;
  logic clock, osc_clk, nrst, ce, store_key, scale_key, comp_up, power_up;
  logic [7:0] preset_key; // preset keys
  logic serial_word_i, serial_word_o, serial_word_oe, pulse_out, mute;
  tvsc_mem_t mem_ctl; // memory lines
  int err_count, checked, k, off, loc, n;
  // device under test with shortened counts
  tvsc_ctrl #(.TRACK_CYCLES(40), .RETUNE_CYCLES(400),
    .HALF_CYCLES(5), .SETUP_CYCLES(10), .PROG_CYCLES(50)) i_tvsc_ctrl (
    .clock(clock), .nrst(nrst), .ce(ce), .osc_clk(osc_clk),
    .preset_key(preset_key), .store_key(store_key), .scale_key(scale_key),
    .comp_up(comp_up), .power_up(power_up), .serial_word_i(serial_word_i),
    .serial_word_o(serial_word_o), .serial_word_oe(serial_word_oe),
    .mem_ctl(mem_ctl), .pulse_out(pulse_out), .mute(mute));
  // far-side memory
  tvsc_mem_model i_tvsc_mem_model (.clock(clock), .mem_ctl(mem_ctl),
    .serial_word_o(serial_word_o), .serial_word_oe(serial_word_oe),
    .serial_word_i(serial_word_i));
  // system clock, 10 ns
  initial
  begin
    clock = 1'b0;
    forever #5 clock = ~clock;
  end
  // resonator clock, 12 ns, offset phase
  initial
  begin
    osc_clk = 1'b0;
    #3.7;
    forever #6 osc_clk = ~osc_clk;
  end
  // word expected at a location
  function automatic logic [9:0] exp_word(input int i);
    return 10'(i * 123 + 3);
  endfunction : exp_word
  // compare and count
  task automatic check(input string nm, input logic [10:0] seen, exp);
    checked++;
    if (seen !== exp)
    begin
      err_count++;
      $display("wrong value %s expected %h seen %h", nm, exp, seen);
    end
  endtask : check
  // verdict and end of run
  task automatic close_out;
    $display("checks %0d mismatches %0d", checked, err_count);
    if (err_count == 0 && checked > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask : close_out
  // bounded wait on a command line, sel 1 picks the write command
  task automatic wait_sig(input int sel, input logic v, input int lim);
    logic s;
    for (int i = 0; i < lim; i++)
    begin
      @(posedge clock);
      #1;
      s = sel ? mem_ctl.write_command_out_n : mem_ctl.recall_strobe_n;
      if (s === v) return;
    end
    err_count++;
    $display("wrong value wait %0d expected %b seen timeout", sel, v);
    close_out();
  endtask : wait_sig
  // press one key and follow the recall it starts
  task automatic press(input int l);
    @(negedge clock) preset_key = 8'h01 << l;
    wait_sig(0, 1'b0, 40);
    @(negedge clock) preset_key = 8'h00;
    wait_sig(0, 1'b1, 400);
  endtask : press
  // word seen as high count over one full output period
  task automatic meas(input logic [9:0] e);
    logic [10:0] c;
    c = 11'h000;
    repeat (2100) @(posedge osc_clk);
    repeat (1024)
    begin
      @(posedge osc_clk);
      #1;
      if (pulse_out === 1'b1) c = c + 11'h001;
    end
    check("pulse width", c, {1'b0, e});
  endtask : meas
  // main sequence
  initial
  begin
    {nrst, store_key, scale_key, comp_up, power_up} = 5'h00;
    ce = 1'b1;
    preset_key = 8'h00;
    err_count = 0;
    checked = 0;
    void'($urandom(32'h685A7D13));
    repeat (4) @(negedge clock);
    nrst = 1'b1;
    repeat (4) @(negedge clock);
    // every location recalled in random order
    k = 2 * ($urandom % 4) + 1;
    off = $urandom % 8;
    for (int i = 0; i < 8; i++)
    begin
      loc = (i * k + off) % 8;
      press(loc);
      meas(exp_word(loc));
    end
    // two keys at once start nothing
    @(negedge clock) preset_key = 8'h42;
    n = 0;
    repeat (100)
    begin
      @(posedge clock);
      #1;
      if (mem_ctl.recall_strobe_n !== 1'b1) n++;
    end
    check("two keys", 11'(n), 11'h000);
    @(negedge clock) preset_key = 8'h00;
    // scale mode counts down from 3 and stops at zero
    press(0);
    @(negedge clock) scale_key = 1'b1;
    // random enable gaps only slow the count down
    repeat (800) @(negedge clock) ce = ($urandom % 4) != 0;
    ce = 1'b1;
    scale_key = 1'b0;
    meas(10'h000);
    // store first, then the preset key; word stays at zero
    loc = $urandom % 8;
    @(negedge clock) store_key = 1'b1;
    repeat (10) @(negedge clock);
    check("mute store held", {10'h000, mute}, 11'h001);
    // a comparator turn stands for equality for a while
    comp_up = 1'b1;
    repeat (6) @(negedge clock);
    check("mute at turn", {10'h000, mute}, 11'h000);
    comp_up = 1'b0;
    repeat (60) @(negedge clock);
    check("mute after turn", {10'h000, mute}, 11'h001);
    preset_key = 8'h01 << loc;
    wait_sig(1, 1'b0, 600);
    @(negedge clock) {store_key, preset_key} = 9'h000;
    wait_sig(1, 1'b1, 300);
    wait_sig(0, 1'b0, 200);
    wait_sig(0, 1'b1, 300);
    check("stored word", {1'b0, i_tvsc_mem_model.mem[loc]}, 11'h000);
    meas(10'h000);
    // power-up rise with one key held recalls again
    @(negedge clock) preset_key = 8'h04;
    wait_sig(0, 1'b0, 40);
    wait_sig(0, 1'b1, 400);
    @(negedge clock) power_up = 1'b1;
    wait_sig(0, 1'b0, 40);
    wait_sig(0, 1'b1, 400);
    @(negedge clock) preset_key = 8'h00;
    meas(exp_word(2));
    close_out();
  end
endmodule : tb_tvsc_ctrl
bind tvsc_ctrl tvsc_ctrl_monitor #(.HALF_CYCLES(HALF_CYCLES))
  i_tvsc_ctrl_monitor (.clock(clock), .nrst(nrst), .mem_ctl(mem_ctl),
  .serial_word_oe(serial_word_oe), .mute(mute));
